/* design/quadrature_irq_enable.sv */
// Functional notes
// - set register: bits 0-4 per event, write 1 enables, read shows enable
// - clear register: same bits, write 1 disables, read shows enable
// - report event fires at period end only when motion accumulator nonzero
// - no report event when no motion since accumulator cleared
// - double event fires at period end only when double accumulator nonzero
// - double event only after a double transition since last clear
// - stopped event raised when the decoder stops; fifth interrupt source
//
// Local design decision: register access over APB.
`include "qirq_defs.svh"
module quadrature_irq_enable #(
   parameter int NUM_EVENTS = `QIRQ_NUM_EVENTS
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_ready_event,
   input wire logic report_period_tick,
   input wire logic accumulator_overflow_event,
   input wire logic decoder_stopped,
   input wire logic motion_accumulator_nonzero,
   input wire logic double_transition_accumulator_nonzero,
   output logic [2:0] report_period_setting,
   output logic [4:0] event_flags,
   output logic irq
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [4:0] enable;
      logic [4:0] status;
      logic [4:0] mask;
      logic [2:0] period;
      logic irq;
   } top_state_t;

   top_state_t st;
   top_state_t next_st;
   qirq_pkg::apb_req_t req;
   qirq_pkg::core_evt_t core_evt;
   logic wr_stb;
   logic rd_stb;
   logic [11:0] acc_addr;
   logic [4:0] evt_pulse;
   logic [4:0] wbits;

   assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};
   assign core_evt = '{sample: sample_ready_event, report_tick: report_period_tick,
                       overflow: accumulator_overflow_event, stopped: decoder_stopped,
                       motion_nz: motion_accumulator_nonzero,
                       double_nz: double_transition_accumulator_nonzero};
   assign wbits = pwdata[4:0];

   // ****************************************
   // submodules
   // ****************************************
   qirq_apb_slave u_slave (
      .core_clk(core_clk),
      .nrst(nrst),
      .req(req),
      .pready(pready),
      .pslverr(pslverr),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .acc_addr(acc_addr)
   );

   qirq_report_gate u_gate (
      .core_clk(core_clk),
      .nrst(nrst),
      .evt_in(core_evt),
      .evt_pulse(evt_pulse)
   );

   // ****************************************
   // register file and interrupt
   // ****************************************
   always_comb begin
      next_st = st;
      // a read of the status register clears it, but a new event wins
      if (rd_stb && acc_addr == `QIRQ_OFF_EVENT_STATUS) begin
         next_st.status = '0;
      end
      next_st.status = next_st.status | evt_pulse;
      if (wr_stb) begin
         case (acc_addr)
            `QIRQ_OFF_ENABLE_SET: next_st.enable = st.enable | wbits;
            `QIRQ_OFF_ENABLE_CLEAR: next_st.enable = st.enable & ~wbits;
            `QIRQ_OFF_EVENT_MASK: next_st.mask = wbits;
            `QIRQ_OFF_REPORT_PERIOD: next_st.period = pwdata[2:0];
            default: next_st.enable = st.enable;
         endcase
      end
      next_st.irq = |(next_st.status & next_st.enable & next_st.mask);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '{enable: `QIRQ_RST_ENABLE, status: 5'h00, mask: `QIRQ_RST_MASK,
                 period: `QIRQ_RST_PERIOD, irq: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // read mux straight off the registers: it stands through the whole access
   // cycle, which lets pready answer with no wait state
   always_comb begin
      prdata = 32'h0000_0000;
      case (acc_addr)
         // both registers read back the one shared enable state
         `QIRQ_OFF_ENABLE_SET: prdata = {27'h0, st.enable};
         `QIRQ_OFF_ENABLE_CLEAR: prdata = {27'h0, st.enable};
         `QIRQ_OFF_EVENT_STATUS: prdata = {27'h0, st.status};
         `QIRQ_OFF_EVENT_MASK: prdata = {27'h0, st.mask};
         `QIRQ_OFF_REPORT_PERIOD: prdata = {29'h0, st.period};
         default: prdata = 32'h0000_0000;
      endcase
   end

   assign irq = st.irq;
   assign event_flags = st.status;
   assign report_period_setting = st.period;

   // ****************************************
   // assertions
   // ****************************************
   property p_set_w1s;
      @(posedge core_clk) disable iff (!nrst)
      wr_stb && acc_addr == `QIRQ_OFF_ENABLE_SET |=> (st.enable & $past(wbits)) == $past(wbits);
   endproperty
   a_set_w1s: assert property (p_set_w1s) else $error("set write did not enable");

   property p_set_keep;
      @(posedge core_clk) disable iff (!nrst)
      wr_stb && acc_addr == `QIRQ_OFF_ENABLE_SET |=> (st.enable & $past(st.enable)) == $past(st.enable);
   endproperty
   a_set_keep: assert property (p_set_keep) else $error("set write cleared an enable");

   property p_clr_w1c;
      @(posedge core_clk) disable iff (!nrst)
      wr_stb && acc_addr == `QIRQ_OFF_ENABLE_CLEAR |=> (st.enable & $past(wbits)) == 5'h00;
   endproperty
   a_clr_w1c: assert property (p_clr_w1c) else $error("clear write did not disable");

   property p_clr_read;
      @(posedge core_clk) disable iff (!nrst)
      pready && !pwrite && paddr == `QIRQ_OFF_ENABLE_CLEAR |-> prdata == {27'h0, st.enable};
   endproperty
   a_clr_read: assert property (p_clr_read) else $error("clear readback wrong");

   property p_irq_level;
      @(posedge core_clk) disable iff (!nrst)
      ##1 irq == |(st.status & st.enable & st.mask);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq disagrees with flags");

   property p_evt_sticky;
      @(posedge core_clk) disable iff (!nrst)
      |evt_pulse |=> (event_flags & $past(evt_pulse)) == $past(evt_pulse);
   endproperty
   a_evt_sticky: assert property (p_evt_sticky) else $error("event flag lost");

   property p_stop_irq;
      @(posedge core_clk) disable iff (!nrst)
      decoder_stopped && st.enable[`QIRQ_BIT_STOPPED] && st.mask[`QIRQ_BIT_STOPPED] && !wr_stb
         |-> ##2 irq;
   endproperty
   a_stop_irq: assert property (p_stop_irq) else $error("stopped gave no irq");

   c_set: cover property (@(posedge core_clk) wr_stb && acc_addr == `QIRQ_OFF_ENABLE_SET);
   c_clr: cover property (@(posedge core_clk) wr_stb && acc_addr == `QIRQ_OFF_ENABLE_CLEAR);
   c_irq: cover property (@(posedge core_clk) $rose(irq));
   c_rdclr: cover property (@(posedge core_clk) rd_stb && acc_addr == `QIRQ_OFF_EVENT_STATUS && irq);
endmodule

/* design/qirq_defs.svh */
`ifndef QIRQ_DEFS_SVH
`define QIRQ_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define QIRQ_OFF_ENABLE_SET 12'h304
`define QIRQ_OFF_ENABLE_CLEAR 12'h308
`define QIRQ_OFF_EVENT_STATUS 12'h30c
`define QIRQ_OFF_EVENT_MASK 12'h310
`define QIRQ_OFF_REPORT_PERIOD 12'h314
// ****************************************
// field positions and reset values
// ****************************************
`define QIRQ_BIT_SAMPLE 0
`define QIRQ_BIT_REPORT 1
`define QIRQ_BIT_OVERFLOW 2
`define QIRQ_BIT_DOUBLE 3
`define QIRQ_BIT_STOPPED 4
`define QIRQ_NUM_EVENTS 5
`define QIRQ_RST_ENABLE 5'h00
`define QIRQ_RST_MASK 5'h1f
`define QIRQ_RST_PERIOD 3'h0
`endif

/* design/qirq_pkg.sv */
package qirq_pkg;
   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic sample;
      logic report_tick;
      logic overflow;
      logic stopped;
      logic motion_nz;
      logic double_nz;
   } core_evt_t;

   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_ACCESS = 2'b01
   } apb_state_t;
endpackage

/* design/qirq_report_gate.sv */
`include "qirq_defs.svh"
// ****************************************
// report-period qualification of accumulator events
// ****************************************
module qirq_report_gate (
   input wire logic core_clk,
   input wire logic nrst,
   input wire qirq_pkg::core_evt_t evt_in,
   output logic [4:0] evt_pulse
);
   typedef struct packed {
      logic [4:0] pulse;
   } gate_state_t;

   gate_state_t st;
   gate_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.pulse[`QIRQ_BIT_SAMPLE] = evt_in.sample;
      // empty accumulator at period end means no motion since last clear
      next_st.pulse[`QIRQ_BIT_REPORT] = evt_in.report_tick & evt_in.motion_nz;
      next_st.pulse[`QIRQ_BIT_OVERFLOW] = evt_in.overflow;
      next_st.pulse[`QIRQ_BIT_DOUBLE] = evt_in.report_tick & evt_in.double_nz;
      next_st.pulse[`QIRQ_BIT_STOPPED] = evt_in.stopped;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign evt_pulse = st.pulse;

   property p_report_gate;
      @(posedge core_clk) disable iff (!nrst)
      evt_in.report_tick && !evt_in.motion_nz |=> !evt_pulse[`QIRQ_BIT_REPORT];
   endproperty
   a_report_gate: assert property (p_report_gate) else $error("report fired on empty accumulator");

   property p_report_fire;
      @(posedge core_clk) disable iff (!nrst)
      evt_in.report_tick && evt_in.motion_nz |=> evt_pulse[`QIRQ_BIT_REPORT];
   endproperty
   a_report_fire: assert property (p_report_fire) else $error("report event missing");

   property p_double_fire;
      @(posedge core_clk) disable iff (!nrst)
      evt_in.report_tick && evt_in.double_nz |=> evt_pulse[`QIRQ_BIT_DOUBLE];
   endproperty
   a_double_fire: assert property (p_double_fire) else $error("double event missing");

   property p_double_gate;
      @(posedge core_clk) disable iff (!nrst)
      $rose(evt_pulse[`QIRQ_BIT_DOUBLE]) |-> $past(evt_in.double_nz);
   endproperty
   a_double_gate: assert property (p_double_gate) else $error("double fired with no transition");

   property p_stop_pass;
      @(posedge core_clk) disable iff (!nrst)
      evt_in.stopped |=> evt_pulse[`QIRQ_BIT_STOPPED];
   endproperty
   a_stop_pass: assert property (p_stop_pass) else $error("stopped event lost");
endmodule

/* design/qirq_apb_slave.sv */
`include "qirq_defs.svh"
// ****************************************
// apb slave front end, zero wait states
// ****************************************
module qirq_apb_slave (
   input wire logic core_clk,
   input wire logic nrst,
   input wire qirq_pkg::apb_req_t req,
   output logic pready,
   output logic pslverr,
   output logic wr_stb,
   output logic rd_stb,
   output logic [11:0] acc_addr
);
   typedef struct packed {
      qirq_pkg::apb_state_t phase;
   } slv_state_t;

   slv_state_t st;
   slv_state_t next_st;
   logic mapped;

   always_comb begin
      next_st = st;
      case (st.phase)
         qirq_pkg::APB_IDLE: begin
            if (req.psel && !req.penable) begin
               next_st.phase = qirq_pkg::APB_ACCESS;
            end
         end
         qirq_pkg::APB_ACCESS: begin
            next_st.phase = qirq_pkg::APB_IDLE;
         end
         default: begin
            next_st.phase = qirq_pkg::APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st <= '{phase: qirq_pkg::APB_IDLE};
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      case (req.paddr)
         `QIRQ_OFF_ENABLE_SET,
         `QIRQ_OFF_ENABLE_CLEAR,
         `QIRQ_OFF_EVENT_STATUS,
         `QIRQ_OFF_EVENT_MASK,
         `QIRQ_OFF_REPORT_PERIOD: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // answer in the first access cycle; an access phase with no setup before it gets no answer
   assign pready = req.psel & req.penable & (st.phase == qirq_pkg::APB_ACCESS);
   assign pslverr = pready & ~mapped;
   assign wr_stb = pready & req.pwrite & mapped;
   assign rd_stb = pready & ~req.pwrite & mapped;
   assign acc_addr = req.paddr;
endmodule

/* verif/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // clock, reset and design hookup
   // ****************************************
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sample_ready_event = 1'b0;
   logic report_period_tick = 1'b0;
   logic accumulator_overflow_event = 1'b0;
   logic decoder_stopped = 1'b0;
   logic motion_accumulator_nonzero = 1'b0;
   logic double_transition_accumulator_nonzero = 1'b0;
   logic [2:0] report_period_setting;
   logic [4:0] event_flags;
   logic irq;
   int mismatches = 0;
   int n_compared = 0;
   logic [4:0] en = 5'h00;
   logic [4:0] mask = 5'h1f;
   logic [4:0] flags = 5'h00;
   logic [31:0] rd;
   logic err;
   logic [31:0] r;

   always #2 core_clk = ~core_clk;

   quadrature_irq_enable DUT (
      .core_clk(core_clk),
      .nrst(nrst),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .sample_ready_event(sample_ready_event),
      .report_period_tick(report_period_tick),
      .accumulator_overflow_event(accumulator_overflow_event),
      .decoder_stopped(decoder_stopped),
      .motion_accumulator_nonzero(motion_accumulator_nonzero),
      .double_transition_accumulator_nonzero(double_transition_accumulator_nonzero),
      .report_period_setting(report_period_setting),
      .event_flags(event_flags),
      .irq(irq)
   );

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic exp_irq(input logic [4:0] f, input logic [4:0] e, input logic [4:0] m);
      return |(f & e & m);
   endfunction

   task print_verdict;
      if (mismatches == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // entered just after a rising edge; leaves one edge after the release
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge core_clk);
      end
      if (n == 50) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   // bits: 0 sample, 1 period tick, 2 overflow, 3 stopped, 4 motion nonzero, 5 double nonzero
   task automatic fire(input logic [5:0] v);
      sample_ready_event <= v[0];
      report_period_tick <= v[1];
      accumulator_overflow_event <= v[2];
      decoder_stopped <= v[3];
      motion_accumulator_nonzero <= v[4];
      double_transition_accumulator_nonzero <= v[5];
      @(posedge core_clk);
      {sample_ready_event, report_period_tick, accumulator_overflow_event} <= 3'h0;
      decoder_stopped <= 1'b0;
      motion_accumulator_nonzero <= 1'b0;
      double_transition_accumulator_nonzero <= 1'b0;
      flags = flags | {v[3], v[1] & v[5], v[2], v[1] & v[4], v[0]};
      repeat (3) @(posedge core_clk);
   endtask

   // irq is registered off the next register state, so it moves on the same edge as a register write
   task automatic check_state;
      repeat (2) @(posedge core_clk);
      check({27'h0, event_flags}, {27'h0, flags});
      check({31'h0, irq}, {31'h0, exp_irq(flags, en, mask)});
      apb(1'b0, 12'h304, 32'h0);
      check(rd, {27'h0, en});
      apb(1'b0, 12'h308, 32'h0);
      check(rd, {27'h0, en});
   endtask

   task automatic read_status;
      apb(1'b0, 12'h30c, 32'h0);
      check(rd, {27'h0, flags});
      flags = 5'h00;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(85334));
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      check_state();
      apb(1'b0, 12'h310, 32'h0);
      check(rd, 32'h1f);
      apb(1'b0, 12'h314, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, 12'h400, 32'hffffffff);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 12'h400, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      check_state();
      apb(1'b1, 12'h304, 32'hffffffff);
      en = 5'h1f;
      fire(6'h02);
      check_state();
      fire(6'h12);
      check_state();
      read_status();
      fire(6'h22);
      check_state();
      fire(6'h08);
      check_state();
      apb(1'b1, 12'h310, 32'h0);
      mask = 5'h00;
      check_state();
      apb(1'b1, 12'h310, 32'h1f);
      mask = 5'h1f;
      read_status();
      apb(1'b1, 12'h314, 32'h5);
      check({29'h0, report_period_setting}, 32'h5);
      // corner: a stopped event lands in the very cycle of the clearing read
      decoder_stopped <= 1'b1;
      fork
         read_status();
         begin
            @(posedge core_clk);
            decoder_stopped <= 1'b0;
         end
      join
      flags = 5'h10;
      check_state();
      repeat (60) begin
         r = $urandom;
         case (r[1:0])
            2'd0: begin
               apb(1'b1, 12'h304, r >> 2);
               en = en | r[6:2];
            end
            2'd1: begin
               apb(1'b1, 12'h308, r >> 2);
               en = en & ~r[6:2];
            end
            2'd2: fire(r[7:2]);
            default: read_status();
         endcase
         check_state();
      end
      // reset in mid-run: everything returns to its reset value
      nrst <= 1'b0;
      @(posedge core_clk);
      nrst <= 1'b1;
      en = 5'h00;
      mask = 5'h1f;
      flags = 5'h00;
      @(posedge core_clk);
      check({29'h0, report_period_setting}, 32'h0);
      check_state();
      print_verdict();
   end

   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
endmodule
